// ---- pkg/adccs_pkg.sv ----
// Constants, field layout and enumerations of the converter control block.
// Assumes a single 24-bit control word and two coefficient pairs, one per channel.
package adccs_pkg;
    localparam int WORD_BITS = 24;
    localparam logic [4:0] WORD_LAST = 5'h17;
    localparam logic [4:0] SHORT_LAST = 5'h0f;
    localparam logic [4:0] TOP_BIT = 5'h17;
    localparam int MODE_MSB = 23;
    localparam int MODE_LSB = 21;
    localparam int GAIN_MSB = 20;
    localparam int GAIN_LSB = 18;
    localparam int SEL_POS = 17;
    localparam int PD_POS = 16;
    localparam int WL_POS = 15;
    localparam int BO_POS = 13;
    localparam int POL_POS = 12;
    localparam int FILT_MSB = 11;
    localparam int FILT_LSB = 0;
    localparam logic [23:0] CTRL_RESET = 24'h000140;
    localparam logic [23:0] ZERO_COEF_RESET = 24'h000000;
    localparam logic [23:0] FULL_COEF_RESET = 24'h800000;
    localparam logic [1:0] SETTLE_LAST = 2'h2;
    localparam logic [2:0] BG_LAST = 3'h5;
    localparam logic [2:0] BG_OUT = 3'h0;
    localparam logic [2:0] BG_SHORTED = 3'h1;
    localparam logic [2:0] BG_REF = 3'h2;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b000,
        MODE_SELF_CAL = 3'b001,
        MODE_SYS_ZERO = 3'b010,
        MODE_SYS_FULL = 3'b011,
        MODE_SYS_OFFSET = 3'b100,
        MODE_BACKGROUND = 3'b101,
        MODE_ZERO_COEF = 3'b110,
        MODE_FULL_COEF = 3'b111
    } adccs_mode_e;

    typedef enum logic [1:0] {
        SRC_CHANNEL = 2'b00,
        SRC_SHORTED = 2'b01,
        SRC_REFERENCE = 2'b10
    } adccs_src_e;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ZERO = 2'b01,
        SEQ_FULL = 2'b10,
        SEQ_BACK = 2'b11
    } adccs_seq_e;
endpackage

// ---- core/adccs_top.sv ----
// Control register, coefficient access and calibration sequencer of a serial converter.
// Assumes a host framing its accesses with the two frame syncs and a filter that pulses conv_strobe.
//
// Function
// - Select low: writes load the control word, reads return it.
// - Control word loads only after all 24 bits; short frames are dropped.
// - Serial clock pulses beyond the 24th within a write frame are ignored.
// - Word layout: mode, gain, selector, power-down, length, spare, burnout, polarity, filter.
// - Mode zero is normal, reads give conversion data; reset default.
// - Mode 001: zero on shorted inputs, full on reference, flag, back to normal.
// - Mode 010: zero-scale on selected channel, flag, back to normal.
// - Mode 011: full-scale on selected channel, flag, back to normal.
// - Mode 100: zero on channel, full on reference, flag, back to normal.
// - Mode 101: background calibration interleaved, coefficients updated, word rate divided by six.
// - Mode 110 with select high accesses the zero-scale coefficient of the channel.
// - Mode 111 with select high accesses the full-scale coefficient of the channel.
// - Coefficient transfers are 24 bits always; writes commit only when complete.
// - Data-ready falls on a new word, rises after it is sent, flags calibration.
// - Data output enabled only with receive sync low; conversion data reads also need data-ready low.
// - Length bit clear gives 16-bit data words, set gives 24-bit; control and coefficient reads are 24-bit.
`timescale 1ns/1ps
module adccs_top
    import adccs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic serial_clock,
    input wire logic register_select,
    input wire logic transmit_frame_sync_n,
    input wire logic receive_frame_sync_n,
    input wire logic serial_data_io_in,
    output logic serial_data_io_out,
    output logic serial_data_io_oe_n,
    output logic data_ready_n,
    input wire logic [adccs_pkg::WORD_BITS-1:0] conv_word,
    input wire logic conv_strobe,
    output logic [2:0] operating_mode_field,
    output logic [2:0] gain_field,
    output logic input_selector,
    output logic power_down_bit,
    output logic word_length_bit,
    output logic burnout_current_bit,
    output logic polarity_bit,
    output logic [11:0] filter_code_field,
    output logic [1:0] cal_source,
    output logic [adccs_pkg::WORD_BITS-1:0] zero_coef_word,
    output logic [adccs_pkg::WORD_BITS-1:0] full_coef_word
);
    import adccs_pkg::*;

    // ==========================================================
    // Link side, write path
    // ==========================================================
    typedef struct packed {
        logic [4:0] cnt;
        logic [23:0] sh;
    } adccs_wfr_s;

    typedef struct packed {
        logic [23:0] word;
        logic rsel;
        logic tog;
    } adccs_whd_s;

    adccs_wfr_s wf;
    adccs_wfr_s next_wf;
    adccs_whd_s wh;
    adccs_whd_s next_wh;

    always_comb begin
        next_wf = wf;
        next_wh = wh;
        if (wf.cnt <= WORD_LAST) begin
            next_wf.sh = {wf.sh[22:0], serial_data_io_in};
            next_wf.cnt = wf.cnt + 5'h01;
        end
        if (wf.cnt == WORD_LAST) begin
            next_wh.word = {wf.sh[22:0], serial_data_io_in};
            next_wh.rsel = register_select;
            next_wh.tog = ~wh.tog;
        end
    end

    // The frame counter is cleared while the sync is high, so a short frame never completes.
    always_ff @(posedge serial_clock or posedge transmit_frame_sync_n) begin
        if (transmit_frame_sync_n) begin
            wf <= '0;
        end else begin
            wf <= next_wf;
        end
    end

    always_ff @(posedge serial_clock or posedge rst) begin
        if (rst) begin
            wh <= '0;
        end else begin
            wh <= next_wh;
        end
    end

    // ==========================================================
    // Link side, read path
    // ==========================================================
    logic [4:0] ridx;
    logic [4:0] next_ridx;
    logic rtog;
    logic next_rtog;
    logic [23:0] tx_word;
    logic tx_len24;
    logic tx_data;
    logic [4:0] rlast;
    logic [4:0] rbit;

    always_comb begin
        rlast = tx_len24 ? WORD_LAST : SHORT_LAST;
        rbit = TOP_BIT - ridx;
        next_ridx = ridx;
        next_rtog = rtog;
        if (ridx <= rlast) begin
            next_ridx = ridx + 5'h01;
        end
        if (ridx == rlast) begin
            next_rtog = ~rtog;
        end
    end

    always_ff @(negedge serial_clock or posedge receive_frame_sync_n) begin
        if (receive_frame_sync_n) begin
            ridx <= '0;
        end else begin
            ridx <= next_ridx;
        end
    end

    always_ff @(negedge serial_clock or posedge rst) begin
        if (rst) begin
            rtog <= 1'b0;
        end else begin
            rtog <= next_rtog;
        end
    end

    assign serial_data_io_out = (ridx <= rlast) ? tx_word[rbit] : 1'b0;
    assign serial_data_io_oe_n = receive_frame_sync_n | (tx_data & data_ready_n);

    // ==========================================================
    // System side
    // ==========================================================
    typedef struct packed {
        logic [23:0] ctrl;
        logic [1:0][23:0] zc;
        logic [1:0][23:0] fc;
        logic [23:0] dw;
        logic data_ready_n_n;
        adccs_seq_e seq;
        logic [1:0] settle;
        logic [2:0] slot;
        logic [23:0] txw;
        logic txl;
        logic txd;
        logic [2:0] rfs_s;
        logic [2:0] wt_s;
        logic [2:0] rt_s;
        logic rfs_q;
        logic wt_q;
        logic rt_q;
    } adccs_sys_s;

    adccs_sys_s r;
    adccs_sys_s n;
    adccs_mode_e mode;
    logic ch;
    logic wt_new;
    logic rt_new;
    logic wr_evt;
    logic rd_done;
    logic step_end;

    always_comb begin
        n = r;
        mode = adccs_mode_e'(r.ctrl[MODE_MSB:MODE_LSB]);
        ch = r.ctrl[SEL_POS];
        n.rfs_s = {r.rfs_s[1:0], receive_frame_sync_n};
        n.wt_s = {r.wt_s[1:0], wh.tog};
        n.rt_s = {r.rt_s[1:0], rtog};
        if (r.rfs_s[1] == r.rfs_s[2]) begin
            n.rfs_q = r.rfs_s[2];
        end
        wt_new = (r.wt_s[1] == r.wt_s[2]) ? r.wt_s[2] : r.wt_q;
        rt_new = (r.rt_s[1] == r.rt_s[2]) ? r.rt_s[2] : r.rt_q;
        n.wt_q = wt_new;
        n.rt_q = rt_new;
        wr_evt = wt_new != r.wt_q;
        rd_done = rt_new != r.rt_q;
        step_end = conv_strobe && (r.settle == SETTLE_LAST);
        if (rd_done && r.txd) begin
            n.data_ready_n_n = 1'b1;
        end
        if (conv_strobe && !r.ctrl[PD_POS]) begin
            unique case (r.seq)
                SEQ_IDLE: begin
                    if (r.rfs_q) begin
                        n.dw = conv_word;
                        n.data_ready_n_n = 1'b0;
                    end
                end
                SEQ_ZERO: begin
                    n.settle = r.settle + 2'h1;
                    if (step_end) begin
                        n.zc[ch] = conv_word;
                        n.settle = 2'h0;
                        if (mode == MODE_SELF_CAL || mode == MODE_SYS_OFFSET) begin
                            n.seq = SEQ_FULL;
                        end else begin
                            n.seq = SEQ_IDLE;
                            n.ctrl[MODE_MSB:MODE_LSB] = MODE_NORMAL;
                            n.data_ready_n_n = 1'b0;
                        end
                    end
                end
                SEQ_FULL: begin
                    n.settle = r.settle + 2'h1;
                    if (step_end) begin
                        n.fc[ch] = conv_word;
                        n.settle = 2'h0;
                        n.seq = SEQ_IDLE;
                        n.ctrl[MODE_MSB:MODE_LSB] = MODE_NORMAL;
                        n.data_ready_n_n = 1'b0;
                    end
                end
                SEQ_BACK: begin
                    n.slot = (r.slot == BG_LAST) ? 3'h0 : r.slot + 3'h1;
                    if (r.slot == BG_SHORTED) begin
                        n.zc[ch] = conv_word;
                    end
                    if (r.slot == BG_REF) begin
                        n.fc[ch] = conv_word;
                    end
                    if (r.slot == BG_OUT && r.rfs_q) begin
                        n.dw = conv_word;
                        n.data_ready_n_n = 1'b0;
                    end
                end
            endcase
        end
        if (wr_evt) begin
            if (!wh.rsel) begin
                n.ctrl = wh.word;
                n.settle = 2'h0;
                n.slot = 3'h0;
                unique case (adccs_mode_e'(wh.word[MODE_MSB:MODE_LSB]))
                    MODE_SELF_CAL, MODE_SYS_ZERO, MODE_SYS_OFFSET: begin
                        n.seq = SEQ_ZERO;
                        n.data_ready_n_n = 1'b1;
                    end
                    MODE_SYS_FULL: begin
                        n.seq = SEQ_FULL;
                        n.data_ready_n_n = 1'b1;
                    end
                    MODE_BACKGROUND: begin
                        n.seq = SEQ_BACK;
                    end
                    MODE_NORMAL, MODE_ZERO_COEF, MODE_FULL_COEF: begin
                        n.seq = SEQ_IDLE;
                    end
                endcase
            end else if (mode == MODE_ZERO_COEF) begin
                n.zc[ch] = wh.word;
            end else if (mode == MODE_FULL_COEF) begin
                n.fc[ch] = wh.word;
            end
        end
        // The read snapshot only moves between read frames, so the link sees a steady word.
        if (r.rfs_q && receive_frame_sync_n) begin
            n.txd = register_select && mode != MODE_ZERO_COEF && mode != MODE_FULL_COEF;
            n.txl = !n.txd || r.ctrl[WL_POS];
            if (!register_select) begin
                n.txw = r.ctrl;
            end else if (mode == MODE_ZERO_COEF) begin
                n.txw = r.zc[ch];
            end else if (mode == MODE_FULL_COEF) begin
                n.txw = r.fc[ch];
            end else begin
                n.txw = r.dw;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r <= '0;
            r.ctrl <= CTRL_RESET;
            r.zc <= {ZERO_COEF_RESET, ZERO_COEF_RESET};
            r.fc <= {FULL_COEF_RESET, FULL_COEF_RESET};
            r.data_ready_n_n <= 1'b1;
            r.seq <= SEQ_IDLE;
            r.txl <= 1'b1;
            r.rfs_s <= 3'h7;
            r.rfs_q <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign tx_word = r.txw;
    assign tx_len24 = r.txl;
    assign tx_data = r.txd;
    assign data_ready_n = r.data_ready_n_n;

    // ==========================================================
    // Control word fields and calibration source
    // ==========================================================
    assign operating_mode_field = r.ctrl[MODE_MSB:MODE_LSB];
    assign gain_field = r.ctrl[GAIN_MSB:GAIN_LSB];
    assign input_selector = r.ctrl[SEL_POS];
    assign power_down_bit = r.ctrl[PD_POS];
    assign word_length_bit = r.ctrl[WL_POS];
    assign burnout_current_bit = r.ctrl[BO_POS];
    assign polarity_bit = r.ctrl[POL_POS];
    assign filter_code_field = r.ctrl[FILT_MSB:FILT_LSB];
    assign zero_coef_word = r.zc[ch];
    assign full_coef_word = r.fc[ch];

    always_comb begin
        unique case (r.seq)
            SEQ_ZERO: begin
                cal_source = (mode == MODE_SELF_CAL) ? SRC_SHORTED : SRC_CHANNEL;
            end
            SEQ_FULL: begin
                cal_source = (mode == MODE_SYS_FULL) ? SRC_CHANNEL : SRC_REFERENCE;
            end
            SEQ_BACK: begin
                cal_source = (r.slot == BG_SHORTED) ? SRC_SHORTED :
                    (r.slot == BG_REF) ? SRC_REFERENCE : SRC_CHANNEL;
            end
            SEQ_IDLE: begin
                cal_source = SRC_CHANNEL;
            end
        endcase
    end
endmodule

// ---- test/adccs_host_model.sv ----
// Host side of the framed serial port: writes and reads words on the two frame syncs.
// Assumes the bench calls wr and rd one at a time; the link clock rests low between frames.
`timescale 1ns/1ps
module adccs_host_model (
    output logic serial_clock,
    output logic register_select,
    output logic transmit_frame_sync_n,
    output logic receive_frame_sync_n,
    output logic serial_data_io_in,
    input wire logic serial_data_io_out,
    input wire logic serial_data_io_oe_n
);
    localparam realtime HALF = 62.5;
    // A short low pulse on both syncs clears the link-side counters once the design is listening.
    initial begin
        serial_clock = 1'b0;
        register_select = 1'b0;
        transmit_frame_sync_n = 1'b0;
        receive_frame_sync_n = 1'b0;
        serial_data_io_in = 1'b1;
        #1;
        transmit_frame_sync_n = 1'b1;
        receive_frame_sync_n = 1'b1;
    end
    // ==========
    // Frame tasks
    task automatic wr(input logic sel, input logic [23:0] w, input int n);
        register_select = sel;
        #100 transmit_frame_sync_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_data_io_in = (i < 24) ? w[23 - i] : 1'b1;
            #HALF serial_clock = 1'b1;
            #HALF serial_clock = 1'b0;
        end
        serial_data_io_in = ~serial_data_io_in;
        #HALF transmit_frame_sync_n = 1'b1;
        #100;
    endtask
    task automatic rd(input logic sel, input int n, output logic [23:0] w);
        w = 24'h000000;
        register_select = sel;
        #100 receive_frame_sync_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            #HALF serial_clock = 1'b1;
            w = {w[22:0], serial_data_io_oe_n ? ~serial_data_io_out : serial_data_io_out};
            #HALF serial_clock = 1'b0;
        end
        #HALF receive_frame_sync_n = 1'b1;
        #100;
    endtask
endmodule

// ---- test/adccs_top_sva.sv ----
// Concurrent checks on the converter control block, bound to its top module.
// Assumes one system clock domain with synchronous active-high reset.
`timescale 1ns/1ps
module adccs_top_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic register_select,
    input wire logic receive_frame_sync_n,
    input wire logic serial_data_io_oe_n,
    input wire logic data_ready_n,
    input wire logic conv_strobe,
    input wire logic power_down_bit,
    input wire logic [2:0] operating_mode_field,
    input wire logic [1:0] cal_source
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ==========
    // Checks
    a_oe_needs_sync: assert property (
        !serial_data_io_oe_n |-> !receive_frame_sync_n) else $error("data out enabled outside a read frame");
    a_oe_on_ready: assert property (
        !receive_frame_sync_n && !data_ready_n |-> !serial_data_io_oe_n) else $error("data out not enabled");
    a_oe_refused: assert property (
        !receive_frame_sync_n && register_select && !(operating_mode_field inside {3'b110, 3'b111})
        && data_ready_n |-> serial_data_io_oe_n) else $error("data out enabled without a new word");
    a_cal_ready_high: assert property (
        operating_mode_field inside {3'b001, 3'b010, 3'b011, 3'b100} |-> data_ready_n)
        else $error("ready low during calibration");
    a_self_src: assert property (
        operating_mode_field == 3'b001 |-> cal_source != 2'b00) else $error("self calibration on channel");
    a_sys_src: assert property (
        operating_mode_field inside {3'b010, 3'b011} |-> cal_source == 2'b00) else $error("system step off channel");
    a_offset_src: assert property (
        operating_mode_field == 3'b100 |-> cal_source != 2'b01) else $error("offset step on shorted inputs");
    a_cal_end_norm: assert property (
        !$past(rst) && ($past(operating_mode_field) inside {3'b001, 3'b010, 3'b011, 3'b100})
        && operating_mode_field != $past(operating_mode_field) |-> operating_mode_field == 3'b000 && !data_ready_n)
        else $error("calibration did not end in normal mode with ready");
    a_word_ready: assert property (
        conv_strobe && operating_mode_field == 3'b000 && !power_down_bit && receive_frame_sync_n
        && $past(receive_frame_sync_n, 5) |=> !data_ready_n) else $error("new word not flagged");
endmodule
bind adccs_top adccs_top_sva chk_u (.sys_clk, .rst, .register_select, .receive_frame_sync_n, .serial_data_io_oe_n,
    .data_ready_n, .conv_strobe, .power_down_bit, .operating_mode_field, .cal_source);

// ---- test/tb.sv ----
// Self-checking bench for the converter control block.
// Assumes the host model for the serial port and a bench-driven filter strobe.
`timescale 1ns/1ps
module tb;
    import adccs_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b0;
    logic serial_clock, register_select, transmit_frame_sync_n, receive_frame_sync_n;
    logic serial_data_io_in, serial_data_io_out, serial_data_io_oe_n, data_ready_n;
    logic conv_strobe = 1'b0;
    logic [23:0] conv_word = 24'h000000;
    logic [2:0] operating_mode_field, gain_field;
    logic input_selector, power_down_bit, word_length_bit, burnout_current_bit, polarity_bit;
    logic [11:0] filter_code_field;
    logic [1:0] cal_source;
    logic [23:0] zero_coef_word, full_coef_word, got;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    always #5 sys_clk = ~sys_clk;
    adccs_top dut_u (.sys_clk, .rst, .serial_clock, .register_select, .transmit_frame_sync_n,
        .receive_frame_sync_n, .serial_data_io_in, .serial_data_io_out, .serial_data_io_oe_n,
        .data_ready_n, .conv_word, .conv_strobe, .operating_mode_field, .gain_field, .input_selector,
        .power_down_bit, .word_length_bit, .burnout_current_bit, .polarity_bit, .filter_code_field,
        .cal_source, .zero_coef_word, .full_coef_word);
    adccs_host_model host_u (.serial_clock, .register_select, .transmit_frame_sync_n,
        .receive_frame_sync_n, .serial_data_io_in, .serial_data_io_out, .serial_data_io_oe_n);
    // ==========
    // Helpers
    task automatic chk(input string what, input logic [23:0] e, input logic [23:0] s);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic pulse(input logic [23:0] w);
        @(negedge sys_clk) conv_word = w;
        conv_strobe = 1'b1;
        @(negedge sys_clk) conv_strobe = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // ==========
    // Scenarios
    initial begin
        @(negedge sys_clk) rst = 1'b1;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        host_u.rd(1'b0, 24, got);
        chk("ctrl reset", CTRL_RESET, got);
        host_u.wr(1'b0, 24'h16b3c5, 24);
        host_u.wr(1'b0, 24'h000000, 12);
        host_u.rd(1'b0, 24, got);
        chk("ctrl word", 24'h16b3c5, got);
        chk("fields", 24'h16b3c5, {operating_mode_field, gain_field, input_selector, power_down_bit,
            word_length_bit, 1'b0, burnout_current_bit, polarity_bit, filter_code_field});
        host_u.wr(1'b0, 24'h0a0140, 30);
        host_u.rd(1'b0, 24, got);
        chk("long frame", 24'h0a0140, got);
        pulse(24'habcdef);
        chk("ready new", 24'h0, 24'(data_ready_n));
        host_u.rd(1'b1, 16, got);
        chk("data16", 24'h00abcd, got);
        chk("ready sent", 24'h1, 24'(data_ready_n));
        host_u.rd(1'b1, 16, got);
        chk("refused read", 24'h005432, got);
        host_u.wr(1'b0, 24'h0a8140, 24);
        pulse(24'h123456);
        host_u.rd(1'b1, 24, got);
        chk("data24", 24'h123456, got);
        for (int m = 6; m < 8; m++) begin
            host_u.wr(1'b0, {3'(m), 21'h0a8140}, 24);
            host_u.wr(1'b1, 24'h5a5a00 + 24'(m), 24);
            host_u.wr(1'b1, 24'h000000, 20);
            host_u.rd(1'b1, 24, got);
            chk("coef read", 24'h5a5a00 + 24'(m), got);
            chk("coef port", 24'h5a5a00 + 24'(m), m == 6 ? zero_coef_word : full_coef_word);
        end
        chk("zero kept", 24'h5a5a06, zero_coef_word);
        for (int m = 1; m < 5; m++) begin
            host_u.wr(1'b0, {3'(m), 21'h0a8140}, 24);
            for (int k = 1; k <= ((m == 2 || m == 3) ? 3 : 6); k++) begin
                chk("busy ready", 24'h1, 24'(data_ready_n));
                pulse({4'(m), 20'(k)});
            end
            chk("cal mode", 24'h0, 24'(operating_mode_field));
            chk("cal ready", 24'h0, 24'(data_ready_n));
            if (m != 3) chk("zero coef", {4'(m), 20'h3}, zero_coef_word);
            if (m != 2) chk("full coef", {4'(m), 20'(m == 3 ? 3 : 6)}, full_coef_word);
        end
        host_u.rd(1'b1, 24, got);
        chk("cal data", 24'h123456, got);
        host_u.wr(1'b0, {3'h5, 21'h0a8140}, 24);
        pulse(24'h700001);
        chk("bg ready", 24'h0, 24'(data_ready_n));
        pulse(24'h700002);
        pulse(24'h700003);
        chk("bg zero", 24'h700002, zero_coef_word);
        chk("bg full", 24'h700003, full_coef_word);
        host_u.rd(1'b1, 24, got);
        chk("bg data", 24'h700001, got);
        for (int k = 4; k < 8; k++) begin
            chk("bg idle", 24'h1, 24'(data_ready_n));
            pulse(24'h700000 + 24'(k));
        end
        chk("bg next", 24'h0, 24'(data_ready_n));
        give_verdict();
    end
endmodule
